// ---- design/key_edge_pkg.sv ----
package key_edge_pkg;

  // ==========================================================================
  // Register map (byte addresses, one word each)
  localparam logic [11:0] KEY_EDGE_ENABLE_OFFSET = 12'h000;
  localparam logic [11:0] KEY_BIT_SET_OFFSET     = 12'h004;
  localparam logic [11:0] KEY_BIT_CLEAR_OFFSET   = 12'h008;
  localparam logic [11:0] IRQ_STATUS_OFFSET      = 12'h00C;
  localparam logic [11:0] IRQ_MASK_OFFSET        = 12'h010;
  localparam logic [11:0] PIN_LEVEL_OFFSET       = 12'h014;

  // ==========================================================================
  // Widths and reset values
  localparam int          KEY_COUNT              = 8;
  localparam logic [7:0]  KEY_EDGE_ENABLE_RESET  = 8'h00;
  localparam logic [0:0]  IRQ_MASK_RESET         = 1'h0;
  localparam int          IRQ_STATUS_KEY_BIT     = 0;

  // ==========================================================================
  // Bus carrier types
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

endpackage

// ---- design/key_edge_detect.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Two-stage synchroniser per pin followed by a rising-edge detector
module key_edge_detect #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] key_input_pins,
  output logic      [WIDTH-1:0] level_q,
  output logic      [WIDTH-1:0] rise_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage to keep metastability contained
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= '0;
      sync_q  <= '0;
      level_q <= '0;
      rise_q  <= '0;
    end else begin
      meta_q  <= key_input_pins;
      sync_q  <= meta_q;
      level_q <= sync_q;
      rise_q  <= sync_q & ~level_q;
    end
  end

endmodule

// ---- design/key_edge_interrupt.sv ----
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Contract
// - A rising edge on any enabled key pin raises the key interrupt request.
// - Enable bit n gates key pin n alone, so each pin is enabled independently.
// - Reset clears the key enable register to zero so no pin can interrupt.
// - The enable register takes whole-byte writes and single-bit set or clear writes.
// - Pins with a cleared enable bit take no part in detection and stay ordinary ports; the code still edge-detects them and masks them at the OR.
module key_edge_interrupt
  import key_edge_pkg::*;
#(
  parameter int KEYS = KEY_COUNT
) (
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [KEYS-1:0] key_input_pins,
  output logic                 key_press_irq,
  output logic                 irq_q
);

  // ==========================================================================
  // State
  apb_req_type      req;
  logic [KEYS-1:0]  key_edge_enable_reg_q;
  logic [KEYS-1:0]  key_edge_enable_reg_d;
  logic             status_q;
  logic             status_d;
  logic             mask_q;
  logic             mask_d;
  logic [KEYS-1:0]  pin_level;
  logic [KEYS-1:0]  pin_rise;
  logic             key_hit;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // ==========================================================================
  // Pin synchronisation and edge detection
  key_edge_detect #(
    .WIDTH(KEYS)
  ) u_detect (
    .pclk          (pclk),
    .presetn       (presetn),
    .key_input_pins(key_input_pins),
    .level_q       (pin_level),
    .rise_q        (pin_rise)
  );

  // Disabled pins are masked out before the OR; they remain free as ports
  assign key_hit = |(pin_rise & key_edge_enable_reg_q);

  // ==========================================================================
  // APB decode; zero wait states, so the access phase ends on its first edge
  logic wr_en;
  logic rd_en;
  logic hit_enable;
  logic hit_set;
  logic hit_clear;
  logic hit_status;
  logic hit_mask;
  logic hit_level;
  logic mapped;

  assign wr_en      = req.psel && req.penable && req.pwrite;
  assign rd_en      = req.psel && !req.penable && !req.pwrite;
  assign hit_enable = (req.paddr == KEY_EDGE_ENABLE_OFFSET);
  assign hit_set    = (req.paddr == KEY_BIT_SET_OFFSET);
  assign hit_clear  = (req.paddr == KEY_BIT_CLEAR_OFFSET);
  assign hit_status = (req.paddr == IRQ_STATUS_OFFSET);
  assign hit_mask   = (req.paddr == IRQ_MASK_OFFSET);
  assign hit_level  = (req.paddr == PIN_LEVEL_OFFSET);
  assign mapped     = hit_enable | hit_set | hit_clear | hit_status | hit_mask | hit_level;

  // Byte write replaces, set and clear ports touch only the ones written
  always_comb begin
    key_edge_enable_reg_d = key_edge_enable_reg_q;
    if (wr_en && hit_enable) begin
      key_edge_enable_reg_d = req.pwdata[KEYS-1:0];
    end else if (wr_en && hit_set) begin
      key_edge_enable_reg_d = key_edge_enable_reg_q | req.pwdata[KEYS-1:0];
    end else if (wr_en && hit_clear) begin
      key_edge_enable_reg_d = key_edge_enable_reg_q & ~req.pwdata[KEYS-1:0];
    end
  end

  // New edge wins over a write-one-to-clear in the same cycle
  assign status_d = key_hit | (status_q & ~(wr_en && hit_status && req.pwdata[IRQ_STATUS_KEY_BIT]));

  // Mask follows a write to its word; the flop itself loads every edge
  assign mask_d = (wr_en && hit_mask) ? req.pwdata[0] : mask_q;

  // Read data selected in setup, registered for the access phase
  logic [31:0] rdata_d;
  assign rdata_d = !rd_en      ? 32'h0000_0000 :
                   hit_enable  ? {{(32-KEYS){1'b0}}, key_edge_enable_reg_q} :
                   hit_status  ? {31'h0000_0000, status_q} :
                   hit_mask    ? {31'h0000_0000, mask_q} :
                   hit_level   ? {{(32-KEYS){1'b0}}, pin_level} :
                   32'h0000_0000;

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_edge_enable_reg_q <= KEYS'(KEY_EDGE_ENABLE_RESET);
      status_q              <= 1'b0;
      mask_q                <= IRQ_MASK_RESET;
      key_press_irq         <= 1'b0;
      irq_q                 <= 1'b0;
      prdata                <= 32'h0000_0000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
    end else begin
      key_edge_enable_reg_q <= key_edge_enable_reg_d;
      status_q              <= status_d;
      mask_q                <= mask_d;
      key_press_irq         <= key_hit;
      irq_q                 <= status_d & mask_q;
      prdata                <= rdata_d;
      pready                <= req.psel && !req.penable;
      pslverr               <= req.psel && !req.penable && !mapped;
    end
  end

  // ==========================================================================
  // Checks
  property p_rise_irq;
    @(posedge pclk) disable iff (!presetn)
      (|(pin_rise & key_edge_enable_reg_q)) |=> key_press_irq;
  endproperty
  a_rise_irq: assert property (p_rise_irq) else $error("enabled rise gave no request");

  property p_no_spurious;
    @(posedge pclk) disable iff (!presetn)
      key_press_irq |-> $past(|(pin_rise & key_edge_enable_reg_q));
  endproperty
  a_no_spurious: assert property (p_no_spurious) else $error("request without enabled rise");

  property p_pin_gating;
    @(posedge pclk) disable iff (!presetn)
      (key_edge_enable_reg_q == 8'h01 && pin_rise == 8'h02) |=> !key_press_irq;
  endproperty
  a_pin_gating: assert property (p_pin_gating) else $error("pin one fired under bit zero");

  property p_reset_clear;
    @(posedge pclk) $rose(presetn) |-> key_edge_enable_reg_q == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("enable not zero after reset");

  property p_byte_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_enable) |=> key_edge_enable_reg_q == $past(pwdata[7:0]);
  endproperty
  a_byte_write: assert property (p_byte_write) else $error("byte write lost");

  property p_bit_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_set) |=> (key_edge_enable_reg_q & $past(pwdata[7:0])) == $past(pwdata[7:0]);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set failed");

  property p_bit_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_clear) |=> (key_edge_enable_reg_q & $past(pwdata[7:0])) == 8'h00;
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear failed");

  property p_pulse;
    @(posedge pclk) disable iff (!presetn)
      (key_press_irq && !(|(pin_rise & key_edge_enable_reg_q))) |=> !key_press_irq;
  endproperty
  a_pulse: assert property (p_pulse) else $error("request not one cycle");

  property p_sticky;
    @(posedge pclk) disable iff (!presetn)
      key_press_irq |-> status_q;
  endproperty
  a_sticky: assert property (p_sticky) else $error("status missed the request");

  // Sticky status, mask and the level output
  property p_status_set;
    @(posedge pclk) disable iff (!presetn)
      key_hit |=> status_q;
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set by enabled rise");

  property p_status_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_status && pwdata[IRQ_STATUS_KEY_BIT] && !key_hit) |=> !status_q;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status not cleared by write one");

  property p_status_hold;
    @(posedge pclk) disable iff (!presetn)
      (status_q && !(wr_en && hit_status)) |=> status_q;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status dropped on its own");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      1'b1 |=> irq_q == (status_q && $past(mask_q));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("level output not status and mask");

  property p_masked_quiet;
    @(posedge pclk) disable iff (!presetn)
      !mask_q |=> !irq_q;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("level output under a clear mask");

  property p_mask_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_mask) |=> mask_q == $past(pwdata[0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  property p_read_status;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_status) |=> prdata == {31'h0000_0000, $past(status_q)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status read wrong");

  // Bus answer timing and read data
  property p_ready_answer;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> pready;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("no ready after setup");

  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn)
      (pready && penable) |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held past access");

  property p_err_unmapped;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !mapped) |=> pslverr && pready;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error for unmapped word");

  property p_err_with_ready;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");

  property p_read_enable;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_enable) |=> prdata == {{(32-KEYS){1'b0}}, $past(key_edge_enable_reg_q)};
  endproperty
  a_read_enable: assert property (p_read_enable) else $error("enable read wrong");

  property p_read_level;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_level) |=> prdata[KEYS-1:0] == $past(pin_level);
  endproperty
  a_read_level: assert property (p_read_level) else $error("pin level read wrong");

  // Enable register changes only through its three words
  property p_idle_no_write;
    @(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(key_edge_enable_reg_q);
  endproperty
  a_idle_no_write: assert property (p_idle_no_write) else $error("enable moved without write");

  property p_unmapped_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && !(hit_enable || hit_set || hit_clear)) |=> $stable(key_edge_enable_reg_q);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("foreign write moved enable");

  property p_bit_set_keep;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_set) |=> ((key_edge_enable_reg_q ^ $past(key_edge_enable_reg_q)) & ~$past(pwdata[7:0])) == 8'h00;
  endproperty
  a_bit_set_keep: assert property (p_bit_set_keep) else $error("bit set touched other bits");

  property p_bit_clear_keep;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_clear) |=> ((key_edge_enable_reg_q ^ $past(key_edge_enable_reg_q)) & ~$past(pwdata[7:0])) == 8'h00;
  endproperty
  a_bit_clear_keep: assert property (p_bit_clear_keep) else $error("bit clear touched other bits");

  // Reset state of the outputs and fully disabled pins
  property p_reset_outputs;
    @(posedge pclk) $rose(presetn) |-> !key_press_irq && !irq_q && !pready && !pslverr;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not idle after reset");

  property p_disabled_pins;
    @(posedge pclk) disable iff (!presetn)
      (key_edge_enable_reg_q == '0) |=> !key_press_irq;
  endproperty
  a_disabled_pins: assert property (p_disabled_pins) else $error("request with all pins disabled");

endmodule

// ---- dv/key_pad_model.sv ----
`timescale 1ns/1ps
// ==========================================================================
// Key line model: each line follows the commanded level one edge later
module key_pad_model (
  input  wire logic       pclk,
  input  wire logic [7:0] line_level,
  output logic      [7:0] key_input_pins
);
  // The initial value keeps every line at a defined low level, so no pin ever floats
  initial key_input_pins = 8'h00;
  always @(posedge pclk) begin
    key_input_pins <= line_level;
  end
endmodule

// ---- dv/tb_key_edge_interrupt.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
// ==========================================================================
// Bench top
module tb_key_edge_interrupt;
  import key_edge_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, key_press_irq, irq_q, er;
  logic [7:0]  key_input_pins, line_level = 8'h00;
  int          err_count = 0, cmp_count = 0, pulses = 0, base = 0;
  // Ordinary cases: enable mask, line pattern, pulses expected
  logic [7:0]  row_en [6] = '{8'h01, 8'h01, 8'h80, 8'h7F, 8'h00, 8'hFF};
  logic [7:0]  row_pin [6] = '{8'h01, 8'h02, 8'h80, 8'h80, 8'hFF, 8'h10};
  int          row_exp [6] = '{1, 0, 1, 0, 0, 1};

  key_edge_interrupt i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .key_input_pins(key_input_pins), .key_press_irq(key_press_irq), .irq_q(irq_q));
  key_pad_model i_pad (.pclk(pclk), .line_level(line_level), .key_input_pins(key_input_pins));

  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Request pulses counted so a stuck-high output shows as extra pulses
  always @(posedge pclk) begin
    if (key_press_irq === 1'b1) pulses <= pulses + 1;
  end

  // ==========================================================================
  // APB master: setup, then access until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog sized well beyond the whole sequence
  initial begin
    #50000;
    err_count++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, KEY_EDGE_ENABLE_OFFSET, 32'h0);
    `CHK("enable_reset", 32'h00000000, rd)
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, KEY_EDGE_ENABLE_OFFSET, {24'h0, row_en[i]});
      repeat (6) @(posedge pclk);
      // Mask still off, enables changed first, then the request flag cleared
      apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
      base = pulses;
      line_level <= row_pin[i];
      repeat (10) @(posedge pclk);
      `CHK("row_pulses", row_exp[i], pulses - base)
      `CHK("irq_unmasked", 1'b0, irq_q)
      line_level <= 8'h00;
      repeat (6) @(posedge pclk);
    end
    // Single-bit set and clear on top of a byte write
    apb(1'b1, KEY_EDGE_ENABLE_OFFSET, 32'h81);
    apb(1'b1, KEY_BIT_SET_OFFSET, 32'h10);
    apb(1'b1, KEY_BIT_CLEAR_OFFSET, 32'h01);
    apb(1'b0, KEY_EDGE_ENABLE_OFFSET, 32'h0);
    `CHK("bit_set_clear", 32'h00000090, rd)
    `CHK("mapped_ok", 1'b0, er)
    // Masked status drives the level output until written back
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
    apb(1'b1, IRQ_MASK_OFFSET, 32'h1);
    line_level <= 8'h01;
    repeat (10) @(posedge pclk);
    `CHK("irq_disabled_pin", 1'b0, irq_q)
    line_level <= 8'h10;
    repeat (10) @(posedge pclk);
    `CHK("irq_level", 1'b1, irq_q)
    apb(1'b0, PIN_LEVEL_OFFSET, 32'h0);
    `CHK("pin_level", 32'h00000010, rd)
    apb(1'b0, IRQ_MASK_OFFSET, 32'h0);
    `CHK("mask_read", 32'h00000001, rd)
    apb(1'b0, IRQ_STATUS_OFFSET, 32'h0);
    `CHK("status_read", 32'h00000001, rd)
    apb(1'b1, IRQ_STATUS_OFFSET, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("irq_cleared", 1'b0, irq_q)
    // Unmapped address answers with an error
    apb(1'b1, 12'h020, 32'hFF);
    `CHK("unmapped_err", 1'b1, er)
    // Reset in mid-run clears the enables again
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, KEY_EDGE_ENABLE_OFFSET, 32'h0);
    `CHK("enable_rereset", 32'h00000000, rd)
    `CHK("irq_after_reset", 1'b0, irq_q)
    complete_run();
  end
endmodule
